// ---- verilog/tctc_top.sv ----
`timescale 1ns/1ps
`include "tctc_consts.svh"
module tctc_top (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic unit_enable_bit,
  input wire logic sequence_start_bit,
  input wire logic trigger_select_bit,
  input wire logic trigger_edge_rising,
  input wire logic trigger_input_pin,
  input wire logic [3:0] charge_time_field,
  input wire logic [3:0] transfer_time_field,
  input wire logic [6:0] spread_max_field,
  input wire logic spread_enable_bit,
  input wire logic [`TCTC_DIV_W-1:0] transfer_tick_divider,
  input wire logic [`TCTC_DIV_W-1:0] spread_tick_divider,
  input wire logic [2:0] cycle_limit_field,
  input wire logic idle_pin_drive_bit,
  input wire logic [`TCTC_PINS-1:0] per_pin_switch_bits,
  input wire logic [`TCTC_PINS-1:0] channel_pins,
  input wire logic [`TCTC_PINS-1:0] sample_pins,
  input wire logic [`TCTC_PINS-1:0] pin_assigned,
  input wire logic [`TCTC_GROUPS-1:0] group_enable,
  input wire logic [`TCTC_GROUPS-1:0] sample_above_threshold,
  input wire logic done_flag_clear_bit,
  input wire logic error_flag_clear_bit,
  output logic [`TCTC_PINS-1:0] pin_takeover,
  output logic [`TCTC_PINS-1:0] pin_drive_en,
  output logic [`TCTC_PINS-1:0] pin_drive_level,
  output logic [`TCTC_PINS-1:0] switch_close,
  output logic sequence_done_flag,
  output logic cycle_limit_error_flag,
  output logic sequence_busy,
  output tctc_pkg::tctc_count_t group_cycle_count [`TCTC_GROUPS]
);
  import tctc_pkg::*;

  tctc_state_e state;
  tctc_state_e next_state;
  logic [7:0] step_cnt;
  logic [7:0] ext_len;
  logic ext_rising;
  tctc_count_t cycle_num;
  tctc_count_t cycle_limit;
  logic [`TCTC_GROUPS-1:0] reached;
  logic [`TCTC_GROUPS-1:0] reached_now;
  logic all_reached;
  logic ct_tick;
  logic ec_tick;
  logic state_change;
  logic trig_meta;
  logic trig_sync;
  logic trig_prev;
  logic [`TCTC_GROUPS-1:0] samp_meta;
  logic [`TCTC_GROUPS-1:0] samp_sync;
  logic trig_edge;
  logic start_req;
  logic stop_now;

  // Limit field 111 is reserved; it is treated as the largest legal limit.
  function automatic tctc_count_t limit_of(input logic [2:0] sel);
    logic [2:0] s;
    s = (sel > `TCTC_LIMIT_TOP_SEL) ? `TCTC_LIMIT_TOP_SEL : sel;
    return 14'((16'h0001 << (`TCTC_LIMIT_BASE_LOG + 4'(s))) - 16'h0001);
  endfunction

  assign cycle_limit = limit_of(cycle_limit_field); // R22

  // Pins and comparator outputs come from the analog side, so both pass two flops.
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      trig_meta <= 1'b0;
      trig_sync <= 1'b0;
      trig_prev <= 1'b0;
      samp_meta <= '0;
      samp_sync <= '0;
    end
    else
    begin
      trig_meta <= trigger_input_pin;
      trig_sync <= trig_meta;
      trig_prev <= trig_sync;
      samp_meta <= sample_above_threshold;
      samp_sync <= samp_meta;
    end
  end

  assign trig_edge = trigger_edge_rising ? (trig_sync && !trig_prev) : (!trig_sync && trig_prev);
  assign start_req = unit_enable_bit && (state == S_IDLE)
                     && (trigger_select_bit ? trig_edge : sequence_start_bit); // R15

  assign reached_now = reached | samp_sync;
  assign all_reached = &(reached_now | ~group_enable);
  assign stop_now = all_reached || (cycle_num == cycle_limit);
  assign state_change = (next_state != state);
  assign sequence_busy = (state != S_IDLE);

  tctc_tick_div u_transfer_tick_div (
    .sys_clk(sys_clk),
    .rst(rst),
    .clear(state_change),
    .divide(transfer_tick_divider),
    .tick(ct_tick)
  ); // R1

  tctc_tick_div u_spread_tick_div (
    .sys_clk(sys_clk),
    .rst(rst),
    .clear(state_change),
    .divide(spread_tick_divider),
    .tick(ec_tick)
  ); // R2

  always_comb
  begin
    next_state = state;
    unique case (state)
      S_IDLE:
        if (start_req)
          next_state = S_BUF1;
      S_BUF1:
        if (step_cnt == `TCTC_BUF_CYCLES - 8'h01)
          next_state = S_CHARGE; // R3
      S_CHARGE:
        if (ct_tick && step_cnt == 8'(charge_time_field)) // R4
          next_state = (spread_enable_bit && ext_len != 8'h00) ? S_EXTEND : S_BUF2; // R21
      S_EXTEND:
        if (ec_tick && step_cnt == ext_len - 8'h01)
          next_state = S_BUF2; // R5
      S_BUF2:
        if (step_cnt == `TCTC_BUF_CYCLES - 8'h01)
          next_state = S_XFER; // R3
      S_XFER:
        if (ct_tick && step_cnt == 8'(transfer_time_field)) // R4
          next_state = S_BUF3;
      S_BUF3:
        if (step_cnt == `TCTC_BUF_CYCLES - 8'h01)
          next_state = S_COMPARE; // R3
      S_COMPARE:
        next_state = stop_now ? S_IDLE : S_BUF1; // R19 R20
    endcase
    if (!unit_enable_bit)
      next_state = S_IDLE;
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
      state <= S_IDLE;
    else
      state <= next_state;
  end

  // Buffer states count clocks; timed states count ticks of their own divider.
  always_ff @(posedge sys_clk)
  begin
    if (rst || state_change)
      step_cnt <= 8'h00;
    else if (state == S_BUF1 || state == S_BUF2 || state == S_BUF3
             || ((state == S_CHARGE || state == S_XFER) && ct_tick)
             || (state == S_EXTEND && ec_tick))
      step_cnt <= step_cnt + 8'h01;
  end

  // Extend length walks 0 up to max+1 and back down, reversing at both ends.
  always_ff @(posedge sys_clk)
  begin
    if (rst || start_req)
    begin
      ext_len <= 8'h00;
      ext_rising <= 1'b1;
    end
    else if (state == S_COMPARE && next_state == S_BUF1)
    begin
      if (ext_rising && ext_len == {1'b0, spread_max_field} + 8'h01) // R5
      begin
        ext_rising <= 1'b0;
        ext_len <= ext_len - 8'h01;
      end
      else if (!ext_rising && ext_len == 8'h00) // R6
      begin
        ext_rising <= 1'b1;
        ext_len <= 8'h01;
      end
      else
        ext_len <= ext_rising ? ext_len + 8'h01 : ext_len - 8'h01; // R6
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst || start_req)
      cycle_num <= 14'h0001;
    else if (state == S_COMPARE && next_state == S_BUF1)
      cycle_num <= cycle_num + 14'h0001;
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      reached <= '0;
      for (int g = 0; g < `TCTC_GROUPS; g++)
        group_cycle_count[g] <= `TCTC_COUNT_RESET;
    end
    else if (start_req)
    begin
      reached <= '0;
      for (int g = 0; g < `TCTC_GROUPS; g++)
        group_cycle_count[g] <= `TCTC_COUNT_RESET; // R23
    end
    else if (state == S_COMPARE)
    begin
      reached <= reached_now;
      for (int g = 0; g < `TCTC_GROUPS; g++)
        if (group_enable[g] && !reached[g])
          group_cycle_count[g] <= group_cycle_count[g] + 14'h0001; // R23
    end
  end

  // A set in the same cycle as a clear wins, so no stop event is lost.
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      sequence_done_flag <= 1'b0;
    else if (state == S_COMPARE && all_reached && unit_enable_bit)
      sequence_done_flag <= 1'b1; // R16
    else if (done_flag_clear_bit)
      sequence_done_flag <= 1'b0; // R16
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
      cycle_limit_error_flag <= 1'b0;
    else if (state == S_COMPARE && !all_reached && cycle_num == cycle_limit && unit_enable_bit)
      cycle_limit_error_flag <= 1'b1; // R17
    else if (error_flag_clear_bit)
      cycle_limit_error_flag <= 1'b0; // R17
  end

  // Idle drive bit low pulls pins low; high leaves them as floating inputs.
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      pin_takeover <= '0;
      pin_drive_en <= '0;
      pin_drive_level <= '0;
      switch_close <= '0;
    end
    else
    begin
      for (int i = 0; i < `TCTC_PINS; i++)
      begin
        pin_takeover[i] <= unit_enable_bit && pin_assigned[i]; // R12
        if (state != S_IDLE && (channel_pins[i] || sample_pins[i]))
        begin
          pin_drive_en[i] <= channel_pins[i] && (state == S_CHARGE || state == S_EXTEND); // R8
          pin_drive_level[i] <= 1'b1;
          switch_close[i] <= (state == S_XFER); // R8
        end
        else
        begin
          pin_drive_en[i] <= !idle_pin_drive_bit; // R9
          pin_drive_level[i] <= 1'b0;
          switch_close[i] <= per_pin_switch_bits[i]; // R10 R11
        end
      end
    end
  end

  a_buf1_two_cycles: assert property (@(posedge sys_clk) disable iff (rst || !unit_enable_bit) // R3
    (state == S_BUF1 && $past(state) != S_BUF1) |-> ##1 state == S_BUF1 ##1 state == S_CHARGE)
    else $error("first buffer state did not last two clocks");

  a_buf3_two_cycles: assert property (@(posedge sys_clk) disable iff (rst || !unit_enable_bit) // R3
    (state == S_BUF3 && $past(state) != S_BUF3) |-> ##1 state == S_BUF3 ##1 state == S_COMPARE)
    else $error("third buffer state did not last two clocks");

  a_idle_switch_follow: assert property (@(posedge sys_clk) disable iff (rst) // R10
    (state == S_IDLE && $past(state) == S_IDLE) |=> switch_close == $past(per_pin_switch_bits))
    else $error("idle switches do not follow the per-pin bits");

  a_soft_start: assert property (@(posedge sys_clk) disable iff (rst) // R15
    (state == S_IDLE && unit_enable_bit && !trigger_select_bit && sequence_start_bit) |=> state == S_BUF1)
    else $error("start bit did not launch a sequence");

  a_done_flag_sticky: assert property (@(posedge sys_clk) disable iff (rst) // R16
    (sequence_done_flag && !done_flag_clear_bit) |=> sequence_done_flag)
    else $error("done flag dropped without a clear");

  a_limit_flag_set: assert property (@(posedge sys_clk) disable iff (rst || !unit_enable_bit) // R17
    (state == S_COMPARE && !all_reached && cycle_num == cycle_limit) |=> cycle_limit_error_flag && state == S_IDLE)
    else $error("cycle limit stop did not raise the error flag");

  a_compare_loop: assert property (@(posedge sys_clk) disable iff (rst || !unit_enable_bit) // R19
    (state == S_COMPARE && !stop_now) |=> state == S_BUF1 ##2 state == S_CHARGE)
    else $error("compare did not start another cycle");

  a_no_extend_off: assert property (@(posedge sys_clk) disable iff (rst) // R21
    (state == S_CHARGE && !spread_enable_bit) |=> state != S_EXTEND)
    else $error("extend state entered with spreading off");

  a_spread_peak: assert property (@(posedge sys_clk) disable iff (rst) // R5
    (state != S_IDLE) |-> ext_len <= {1'b0, spread_max_field} + 8'h01)
    else $error("extend length above its peak");

  a_count_clear: assert property (@(posedge sys_clk) disable iff (rst) // R23
    start_req |=> group_cycle_count[0] == `TCTC_COUNT_RESET && cycle_num == 14'h0001)
    else $error("counters not cleared at sequence start");
endmodule

// ---- verilog/tctc_consts.svh ----
// Contract
// R1 - Transfer ticks divided from clock time charge/transfer
// R2 - Independent spread tick divider times extend-charge
// R3 - Each buffer state lasts two clocks
// R4 - Charge and transfer durations fixed per sequence
// R5 - Extend peak is max+1 ticks at cycle max+2
// R6 - Extend duration follows a repeating triangle from zero
// R7 - Software sets one sample pin per group only
// R8 - Running sequence drives role pins and switches
// R9 - Idle drive bit sets idle and free pin modes
// R10 - Idle and free switches follow per-pin bits
// R11 - Idle switches follow bits even for unassigned pins
// R12 - Enabled unit overrides other pin owners
// R13 - Software should disable hysteresis on unit pins
// R14 - Software configures before enabling, starts after enabling
// R15 - Start by start bit or trigger pin edge
// R16 - Done flag set on threshold stop, sticky
// R17 - Limit flag set on cycle-limit stop, sticky
// R18 - Software waits for flag, clears, reads counts
// R19 - Compare returns idle when all reached, else loops
// R20 - Stop at cycle limit after compare
// R21 - Extend state only when spread enabled
// R22 - Limit field selects 255 to 16383, top reserved
// R23 - Group counters clear at start, count until threshold
`ifndef TCTC_CONSTS_SVH
`define TCTC_CONSTS_SVH

`define TCTC_GROUPS 6
`define TCTC_PINS_PER_GROUP 4
`define TCTC_PINS 24
`define TCTC_COUNT_W 14
`define TCTC_BUF_CYCLES 8'h02
`define TCTC_LIMIT_BASE_LOG 4'h8
`define TCTC_LIMIT_TOP_SEL 3'h6
`define TCTC_COUNT_RESET 14'h0000
`define TCTC_DIV_W 3
`define TCTC_DIV_CNT_W 7

`endif

// ---- verilog/tctc_pkg.sv ----
package tctc_pkg;
  typedef enum logic [2:0] {
    S_IDLE,
    S_BUF1,
    S_CHARGE,
    S_EXTEND,
    S_BUF2,
    S_XFER,
    S_BUF3,
    S_COMPARE
  } tctc_state_e;
  typedef logic [13:0] tctc_count_t;
endpackage

// ---- verilog/tctc_tick_div.sv ----
`timescale 1ns/1ps
`include "tctc_consts.svh"
module tctc_tick_div (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic clear,
  input wire logic [`TCTC_DIV_W-1:0] divide,
  output logic tick
);
  logic [`TCTC_DIV_CNT_W-1:0] count;
  logic [`TCTC_DIV_CNT_W-1:0] last;

  // Clearing on every state entry keeps each charge, extend and transfer state an exact multiple of the tick period.
  assign last = `TCTC_DIV_CNT_W'((8'h01 << divide) - 8'h01);
  assign tick = (count == last);

  always_ff @(posedge sys_clk)
  begin
    if (rst || clear || tick)
    begin
      count <= '0;
    end
    else
    begin
      count <= count + `TCTC_DIV_CNT_W'(1);
    end
  end
endmodule

// ---- tb/tctc_far_model.sv ----
`timescale 1ns/1ps
module tctc_far_model (
  input wire logic sys_clk,
  input wire logic [23:0] switch_close,
  input wire logic [23:0] drive_en,
  input wire logic [23:0] drive_level,
  input wire logic sequence_busy,
  input wire logic [15:0] need,
  output logic [5:0] sample_above_threshold,
  output logic [15:0] closures = 16'h0000,
  output logic [15:0] charges = 16'h0000
);
  logic prev = 1'b0;
  logic prev_chg = 1'b0;
  // The sample capacitor of group 0 sits on pin 1 and gains one step per transfer closure.
  // A closed switch while idle is the software discharge, so the charge starts from zero.
  // The electrode on pin 0 takes one charge pulse each time it is driven high.
  always @(posedge sys_clk)
  begin
    prev <= switch_close[1];
    prev_chg <= drive_en[0] && drive_level[0];
    if (!sequence_busy && switch_close[1])
    begin
      closures <= 16'h0000;
      charges <= 16'h0000;
    end
    else
    begin
      if (switch_close[1] && !prev)
        closures <= closures + 16'h0001;
      if (drive_en[0] && drive_level[0] && !prev_chg)
        charges <= charges + 16'h0001;
    end
  end
  // The comparator is clean, as for pins whose hysteresis software has turned off.
  assign sample_above_threshold = {5'h00, closures >= need};
endmodule

// ---- tb/tctc_top_tb_top.sv ----
`timescale 1ns/1ps
module tctc_top_tb_top;
  import tctc_pkg::*;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic en = 1'b0, start = 1'b0, tsel = 1'b0, trig = 1'b0, spr = 1'b0, ipd = 1'b0;
  logic dclr = 1'b0, eclr = 1'b0;
  logic [3:0] cf = 4'h0, tf = 4'h0;
  logic [6:0] smax = 7'h00;
  logic [2:0] tdiv = 3'h0, sdiv = 3'h0, lim = 3'h0;
  logic [23:0] swb = 24'h00_0000, asg = 24'h00_000F;
  logic [23:0] takeover, drv_en, sw, lvl;
  logic [15:0] need = 16'h0003, clo, chg;
  logic rise = 1'b1;
  logic [5:0] above;
  logic done, err, busy;
  tctc_count_t cnt [6];
  int fails = 0, check_count = 0, cyc = 0;

  always #10 sys_clk = ~sys_clk;

  tctc_top dut_u (
    .sys_clk(sys_clk),
    .rst(rst),
    .unit_enable_bit(en),
    .sequence_start_bit(start),
    .trigger_select_bit(tsel),
    .trigger_edge_rising(rise),
    .trigger_input_pin(trig),
    .charge_time_field(cf),
    .transfer_time_field(tf),
    .spread_max_field(smax),
    .spread_enable_bit(spr),
    .transfer_tick_divider(tdiv),
    .spread_tick_divider(sdiv),
    .cycle_limit_field(lim),
    .idle_pin_drive_bit(ipd),
    .per_pin_switch_bits(swb),
    .channel_pins(24'h00_0001),
    .sample_pins(24'h00_0002),
    .pin_assigned(asg),
    .group_enable(6'h01),
    .sample_above_threshold(above),
    .done_flag_clear_bit(dclr),
    .error_flag_clear_bit(eclr),
    .pin_takeover(takeover),
    .pin_drive_en(drv_en),
    .pin_drive_level(lvl),
    .switch_close(sw),
    .sequence_done_flag(done),
    .cycle_limit_error_flag(err),
    .sequence_busy(busy),
    .group_cycle_count(cnt)
  );

  tctc_far_model far_u (
    .sys_clk(sys_clk),
    .switch_close(sw),
    .drive_en(drv_en),
    .drive_level(lvl),
    .sequence_busy(busy),
    .need(need),
    .sample_above_threshold(above),
    .closures(clo),
    .charges(chg)
  );

  task automatic summarize();
    if (fails == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // The longest test is the cycle-limit run, well under this ceiling.
  always @(posedge sys_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 30000)
    begin
      fails++;
      summarize();
    end
  end

  task automatic tick(int n = 1);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    check_count++;
    if (got !== exp)
    begin
      fails++;
      $display("mismatch %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  task automatic run(bit by_pin, output int n);
    tsel = by_pin;
    swb = 24'hFF_FFFF;
    tick(3);
    swb = 24'h00_0000;
    tick(1);
    if (by_pin)
      trig = ~trig;
    else
      start = 1'b1;
    tick(1);
    start = 1'b0;
    n = 0;
    repeat (5) if (busy !== 1'b1) tick(1);
    while (busy === 1'b1 && n < 20000)
    begin
      n++;
      tick(1);
    end
  endtask

  task automatic flags(logic d, logic e);
    chk("done", d, done);
    chk("limit", e, err);
    tick(4);
    chk("done held", d, done);
    chk("limit held", e, err);
    dclr = 1'b1;
    eclr = 1'b1;
    tick(1);
    dclr = 1'b0;
    eclr = 1'b0;
    tick(1);
    chk("done cleared", 0, done);
    chk("limit cleared", 0, err);
  endtask

  task automatic t_idle();
    ipd = 1'b0;
    swb = 24'h5A_0000;
    tick(2);
    chk("idle switch", swb, sw);
    chk("idle drive", asg, drv_en & asg);
    chk("idle level", 0, lvl & asg);
    chk("takeover", asg, takeover);
    ipd = 1'b1;
    tick(2);
    chk("idle float", 0, drv_en & asg);
  endtask

  task automatic t_basic();
    int n;
    need = 16'h0003;
    run(0, n);
    chk("cycle count", clo, cnt[0]);
    chk("idle group", 0, cnt[1]);
    chk("charge pulses", clo, chg);
    chk("reached", 1, cnt[0] >= need);
    chk("busy basic", 9 * clo, n);
    flags(1'b1, 1'b0);
  endtask

  task automatic t_limit();
    int n, m;
    need = 16'h03E8;
    for (int v = 0; v < 2; v++)
    begin
      lim = 3'(v);
      m = (256 << v) - 1;
      run(0, n);
      chk("limit count", m, cnt[0]);
      chk("busy limit", 9 * m, n);
      flags(1'b0, 1'b1);
    end
    lim = 3'h0;
  endtask

  task automatic t_spread();
    int n, k, p, l, e;
    need = 16'h0006;
    spr = 1'b1;
    smax = 7'h01;
    sdiv = 3'h2;
    tdiv = 3'h1;
    cf = 4'h1;
    tf = 4'h2;
    run(0, n);
    e = 0;
    for (k = 1; k <= cnt[0]; k++)
    begin
      p = (k - 1) % (2 * smax + 2);
      l = (p <= smax + 1) ? p : 2 * smax + 2 - p;
      e += 7 + (cf + 1) * (1 << tdiv) + l * (1 << sdiv) + (tf + 1) * (1 << tdiv);
    end
    chk("spread count", clo, cnt[0]);
    chk("busy spread", e, n);
    chk("spread charges", clo, chg);
    flags(1'b1, 1'b0);
    spr = 1'b0;
    tdiv = 3'h0;
    cf = 4'h0;
    tf = 4'h0;
  endtask

  task automatic t_trig();
    int n;
    need = 16'h0002;
    // Rising edge first, then falling edge on the same pin.
    for (int r = 1; r >= 0; r--)
    begin
      rise = r[0];
      run(1, n);
      chk("trigger run", 1, n > 0);
      chk("busy trigger", 9 * clo, n);
      flags(1'b1, 1'b0);
    end
  endtask

  initial
  begin
    tick(16);
    rst = 1'b0;
    tick(2);
    en = 1'b1;
    tick(2);
    t_idle();
    t_basic();
    t_limit();
    t_spread();
    t_trig();
    summarize();
  end
endmodule
